// *** pap_pkg.sv ***
package pap_pkg;
   // Clock and timing.
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADC_RATE_HZ = 833_000;
   localparam int SAMPLE_DIV = CLK_HZ / ADC_RATE_HZ;
   localparam int DIV_W = 7;
   localparam int PULSE_TIME_NS = 1_000;
   localparam int PULSE_CYC = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PCNT_W = 8;
   // Bandwidth figures; the filter corners are fractions of the sample rate,
   // which is a fixed division of the master clock.
   localparam int BW_HZ = 14_000;
   localparam int BW_REF_CLK_HZ = 10_000_000;
   // Datapath widths and FIFO depth.
   localparam int SMP_W = 16;
   localparam int FLT_W = 24;
   localparam int PRD_W = 32;
   localparam int LPF_W = 40;
   localparam int SUM_W = 34;
   localparam int ACC_W = 48;
   localparam int FIFO_DEPTH = 4;
   // Filter shifts.
   localparam int HPF_SHIFT = 14;
   localparam int PHC_SHIFT = 2;
   localparam int LPF_SHIFT = 12;
   // Energy to pulse thresholds; the low-rate set is indexed by the two rate select pins, the calibration one is fixed.
   localparam logic [ACC_W-1:0] F_THR [4] = '{
      48'h0000_0400_0000, 48'h0000_0200_0000,
      48'h0000_0100_0000, 48'h0000_0080_0000};
   localparam logic [ACC_W-1:0] CF_THR = 48'h0000_0008_0000;
   // Reset values.
   localparam logic [ACC_W-1:0] ACC_RST = 48'h0000_0000_0000;
endpackage

// *** pap_fifo.sv ***
`timescale 1ns/100ps
module pap_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   wire [AW-1:0] last = AW'(DEPTH - 1);

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rd_q];

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == last) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == last) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   property p_fifo_bound;
      @(posedge clk) disable iff (!rst_n) cnt_q <= (AW+1)'(DEPTH);
   endproperty
   a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");
endmodule

// *** pap_datapath.sv ***
`timescale 1ns/100ps
module pap_datapath (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic supply_valid,
   input wire logic sum_method_select,
   input wire logic rate_select_0,
   input wire logic rate_select_1,
   input wire logic signed [15:0] current_a_pos,
   input wire logic signed [15:0] current_b_pos,
   input wire logic signed [15:0] current_c_pos,
   input wire logic signed [15:0] voltage_a_pos,
   input wire logic signed [15:0] voltage_b_pos,
   input wire logic signed [15:0] voltage_c_pos,
   output logic sample_tick,
   output logic low_rate_pulse_out_1,
   output logic low_rate_pulse_out_2,
   output logic calibration_pulse_out
);
   localparam int FW = pap_pkg::FLT_W;
   localparam int PW = pap_pkg::PRD_W;
   localparam int LW = pap_pkg::LPF_W;
   localparam int SW = pap_pkg::SUM_W;
   localparam int AW = pap_pkg::ACC_W;

   function automatic logic signed [SW-1:0] mag(input logic signed [PW-1:0] v);
      logic signed [SW-1:0] e;
      e = SW'(v);
      mag = (v < 0) ? -e : e;
   endfunction

   // Pins from outside the clock domain pass two flip-flops.
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {supply_valid, sum_method_select, rate_select_1, rate_select_0};
         sync_q <= meta_q;
      end
   end
   wire sup_ok = sync_q[3];
   wire arith = sync_q[2];
   wire [1:0] rate_sel = sync_q[1:0];
   wire dp_rst = !rst_n || !sup_ok;

   logic [pap_pkg::DIV_W-1:0] div_q;
   wire tick = (div_q == pap_pkg::DIV_W'(pap_pkg::SAMPLE_DIV - 1));
   always_ff @(posedge clk) begin
      if (dp_rst) begin
         div_q <= '0;
      end else begin
         div_q <= tick ? '0 : div_q + 1'b1;
      end
   end
   assign sample_tick = tick;

   wire signed [15:0] cur_in [3];
   wire signed [15:0] vol_in [3];
   assign cur_in[0] = current_a_pos;
   assign cur_in[1] = current_b_pos;
   assign cur_in[2] = current_c_pos;
   assign vol_in[0] = voltage_a_pos;
   assign vol_in[1] = voltage_b_pos;
   assign vol_in[2] = voltage_c_pos;
   wire signed [PW-1:0] pw [3];

   for (genvar g = 0; g < 3; g++) begin : g_ph
      logic signed [FW-1:0] xp_q;
      logic signed [FW-1:0] hp_q;
      logic signed [FW-1:0] pc_q;
      logic signed [PW-1:0] prod_q;
      logic signed [LW-1:0] lp_q;
      wire signed [FW-1:0] xs = $signed({cur_in[g], 8'h00});
      wire signed [FW-1:0] hp_d = xs - xp_q + hp_q - (hp_q >>> pap_pkg::HPF_SHIFT);
      wire signed [FW-1:0] pc_d = pc_q + ((hp_q - pc_q) >>> pap_pkg::PHC_SHIFT);
      wire signed [15:0] pc_s = pc_q[FW-1:8];
      wire signed [PW-1:0] prod_d = pc_s * vol_in[g];
      wire signed [LW-1:0] pe = $signed({prod_q, 8'h00});
      wire signed [LW-1:0] lp_d = lp_q + ((pe - lp_q) >>> pap_pkg::LPF_SHIFT);
      always_ff @(posedge clk) begin
         if (dp_rst) begin
            xp_q <= '0;
            hp_q <= '0;
            pc_q <= '0;
            prod_q <= '0;
            lp_q <= '0;
         end else if (tick) begin
            xp_q <= xs;
            hp_q <= hp_d;
            pc_q <= pc_d;
            prod_q <= prod_d;
            lp_q <= lp_d;
         end
      end
      assign pw[g] = lp_q[LW-1:8];
   end

   wire signed [SW-1:0] sum_ar = SW'(pw[0]) + SW'(pw[1]) + SW'(pw[2]);
   wire signed [SW-1:0] sum_ab = mag(pw[0]) + mag(pw[1]) + mag(pw[2]);
   wire signed [SW-1:0] sum_d = arith ? sum_ar : sum_ab;
   logic signed [SW-1:0] sum_q;
   logic sum_v_q;
   logic tick_q;
   wire in_ready;
   // A tick meeting a full FIFO with a total already pending is dropped; the pending total is kept.
   wire sum_load = tick_q && !(sum_v_q && !in_ready);
   always_ff @(posedge clk) begin
      if (dp_rst) begin
         tick_q <= 1'b0;
         sum_q <= '0;
         sum_v_q <= 1'b0;
      end else begin
         tick_q <= tick;
         if (sum_load) begin
            sum_q <= sum_d;
            sum_v_q <= 1'b1;
         end else if (in_ready) begin
            sum_v_q <= 1'b0;
         end
      end
   end

   wire out_valid;
   wire [SW-1:0] out_data;
   logic [pap_pkg::PCNT_W-1:0] pcnt_q;
   // The drain stalls while a low-rate pulse is out.
   wire out_ready = (pcnt_q == '0);
   wire pop = out_valid && out_ready;

   pap_fifo #(
      .WIDTH(SW),
      .DEPTH(pap_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(!dp_rst),
      .in_valid(sum_v_q),
      .in_ready(in_ready),
      .in_data(sum_q),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_data)
   );

   wire [AW-1:0] f_thr = pap_pkg::F_THR[rate_sel];
   wire signed [AW-1:0] w = AW'($signed(out_data));
   logic signed [AW-1:0] f_acc_q;
   logic signed [AW-1:0] cf_acc_q;
   wire signed [AW-1:0] f_sum = f_acc_q + w;
   wire signed [AW-1:0] cf_sum = cf_acc_q + w;
   wire f_fire = pop && (f_sum >= $signed(f_thr));
   wire cf_fire = pop && (cf_sum >= $signed(pap_pkg::CF_THR));
   // Negative energy never drives an accumulator below zero.
   wire signed [AW-1:0] f_acc_d = f_fire ? f_sum - $signed(f_thr) :
                                  (f_sum < 0) ? '0 : f_sum;
   wire signed [AW-1:0] cf_acc_d = cf_fire ? cf_sum - $signed(pap_pkg::CF_THR) :
                                   (cf_sum < 0) ? '0 : cf_sum;

   logic f1_q;
   logic f2_q;
   logic fsel_q;
   logic cf_q;
   always_ff @(posedge clk) begin
      if (dp_rst) begin
         f_acc_q <= pap_pkg::ACC_RST;
         cf_acc_q <= pap_pkg::ACC_RST;
      end else if (pop) begin
         f_acc_q <= f_acc_d;
         cf_acc_q <= cf_acc_d;
      end
   end

   // Low-rate pulses alternate between the two outputs, as a stepper needs.
   always_ff @(posedge clk) begin
      if (dp_rst) begin
         pcnt_q <= '0;
         f1_q <= 1'b0;
         f2_q <= 1'b0;
         fsel_q <= 1'b0;
         cf_q <= 1'b0;
      end else begin
         cf_q <= cf_fire;
         if (f_fire) begin
            pcnt_q <= pap_pkg::PCNT_W'(pap_pkg::PULSE_CYC);
            f1_q <= !fsel_q;
            f2_q <= fsel_q;
            fsel_q <= !fsel_q;
         end else if (pcnt_q != '0) begin
            pcnt_q <= pcnt_q - 1'b1;
            if (pcnt_q == 1) begin
               f1_q <= 1'b0;
               f2_q <= 1'b0;
            end
         end
      end
   end
   assign low_rate_pulse_out_1 = f1_q;
   assign low_rate_pulse_out_2 = f2_q;
   assign calibration_pulse_out = cf_q;

   property p_tick_gap;
      @(posedge clk) disable iff (dp_rst) tick |=> !tick [*8];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("sample ticks too close");

   property p_hpf_hold;
      @(posedge clk) disable iff (dp_rst) !tick |=> $stable(g_ph[0].hp_q);
   endproperty
   a_hpf_hold: assert property (p_hpf_hold) else $error("high-pass moved off tick");

   property p_phc_track;
      @(posedge clk) disable iff (dp_rst)
         tick && (g_ph[1].hp_q > g_ph[1].pc_q) |=> g_ph[1].pc_q >= $past(g_ph[1].pc_q);
   endproperty
   a_phc_track: assert property (p_phc_track) else $error("lag stage moved away");

   property p_mult;
      @(posedge clk) disable iff (dp_rst)
         tick |=> g_ph[0].prod_q == $signed($past(g_ph[0].pc_s)) * $signed($past(vol_in[0]));
   endproperty
   a_mult: assert property (p_mult) else $error("phase product wrong");

   property p_lpf_track;
      @(posedge clk) disable iff (dp_rst)
         tick && (g_ph[2].pe > g_ph[2].lp_q) |=> g_ph[2].lp_q >= $past(g_ph[2].lp_q);
   endproperty
   a_lpf_track: assert property (p_lpf_track) else $error("low-pass moved away");

   property p_sum_arith;
      @(posedge clk) disable iff (dp_rst)
         sum_load && arith |=> sum_q == $past(SW'(pw[0]) + SW'(pw[1]) + SW'(pw[2]));
   endproperty
   a_sum_arith: assert property (p_sum_arith) else $error("arithmetic total wrong");

   property p_sum_abs;
      @(posedge clk) disable iff (dp_rst) sum_load && !arith |=> sum_q >= 0;
   endproperty
   a_sum_abs: assert property (p_sum_abs) else $error("magnitude total negative");

   sequence s_pulse_high;
      (f1_q ^ f2_q) [*8];
   endsequence
   property p_f_pulse;
      @(posedge clk) disable iff (dp_rst) f_fire |=> s_pulse_high;
   endproperty
   a_f_pulse: assert property (p_f_pulse) else $error("low-rate pulse too short");

   property p_f_thr;
      @(posedge clk) disable iff (dp_rst) pop |=> f_acc_q < $signed($past(f_thr));
   endproperty
   a_f_thr: assert property (p_f_thr) else $error("accumulator above threshold");

   property p_cf_pulse;
      @(posedge clk) disable iff (dp_rst) cf_fire |=> cf_q ##1 (cf_q == $past(cf_fire));
   endproperty
   a_cf_pulse: assert property (p_cf_pulse) else $error("calibration pulse wrong");

   property p_rst_quiet;
      @(posedge clk) !dp_rst && $past(dp_rst) |-> !f1_q && !f2_q && !cf_q &&
         f_acc_q == 0 && cf_acc_q == 0 && !sum_v_q;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("state left after reset");

   property p_sup_hold;
      @(posedge clk) disable iff (!rst_n) !sup_ok |=> !tick_q && !f1_q && !cf_q;
   endproperty
   a_sup_hold: assert property (p_sup_hold) else $error("active without supply");

   property p_f_alternate;
      @(posedge clk) disable iff (dp_rst) f_fire |=> f1_q != f2_q && f2_q == $past(fsel_q);
   endproperty
   a_f_alternate: assert property (p_f_alternate) else $error("low-rate outputs not alternating");
endmodule

// *** pap_adc_model.sv ***
`timescale 1ns/100ps
// Converter stand-in: each channel alternates sign on every sample tick, so an
// in-phase current and voltage pair carries a steady positive product.
module pap_adc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sample_tick,
   input wire logic signed [15:0] amp_i [3],
   input wire logic signed [15:0] amp_v [3],
   output logic signed [15:0] cur [3],
   output logic signed [15:0] volt [3]
);
   logic sign_q;
   always_ff @(posedge clk) begin
      if (!rst_n || sample_tick) begin
         sign_q <= rst_n ? ~sign_q : 1'b0;
      end
   end
   // sample on tick
   // Outside the tick the lines show the inverse, so a stray capture is seen.
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         cur[k] = sign_q ? amp_i[k] : -amp_i[k];
         volt[k] = sign_q ? amp_v[k] : -amp_v[k];
         if (!sample_tick) begin
            cur[k] = ~cur[k];
            volt[k] = ~volt[k];
         end
      end
   end
endmodule

// *** polyphase_active_power_datapath_tb_top.sv ***
`timescale 1ns/100ps
module polyphase_active_power_datapath_tb_top;
   logic clk = 0, rst_n = 0, supply_valid = 0, sum_method_select = 1;
   logic rate_select_0 = 0, rate_select_1 = 0;
   logic signed [15:0] amp_i [3] = '{default: 16'h0000};
   logic signed [15:0] amp_v [3] = '{default: 16'h0000};
   logic signed [15:0] cur [3], volt [3];
   logic sample_tick, low_rate_pulse_out_1, low_rate_pulse_out_2, calibration_pulse_out;
   bit notes [$];
   int failures = 0, n_compared = 0;
   int lr_cnt = 0, cf_cnt = 0, width = 0, exp_out = 1, cnt [4], gap = 0;
   logic prev_lr = 0, prev_cf = 0;
   event win_done;

   initial begin
      forever #5 clk = ~clk;
   end

   pap_adc_model pap_adc_model_inst (.clk(clk), .rst_n(supply_valid),
      .sample_tick(sample_tick), .amp_i(amp_i), .amp_v(amp_v), .cur(cur), .volt(volt));
   pap_datapath pap_datapath_inst (.clk(clk), .rst_n(rst_n), .supply_valid(supply_valid),
      .sum_method_select(sum_method_select), .rate_select_0(rate_select_0),
      .rate_select_1(rate_select_1), .current_a_pos(cur[0]), .current_b_pos(cur[1]),
      .current_c_pos(cur[2]), .voltage_a_pos(volt[0]), .voltage_b_pos(volt[1]),
      .voltage_c_pos(volt[2]), .sample_tick(sample_tick),
      .low_rate_pulse_out_1(low_rate_pulse_out_1), .low_rate_pulse_out_2(low_rate_pulse_out_2),
      .calibration_pulse_out(calibration_pulse_out));

   task automatic check(string what, logic [47:0] exp, logic [47:0] got);
      n_compared++;
      if (exp !== got) begin
         failures++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic end_of_test();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Watches pulse order, width and count; a pulse cut by reset is not judged.
   always @(posedge clk) begin
      if (!supply_valid) begin
         exp_out = 1;
         width = 0;
         lr_cnt = 0;
         cf_cnt = 0;
         gap = 0;
      end else begin
         if (low_rate_pulse_out_1 || low_rate_pulse_out_2) begin
            if (!prev_lr) begin
               check("low rate output", 48'(exp_out == 1), 48'(low_rate_pulse_out_1));
               check("low rate other", 48'(exp_out == 2), 48'(low_rate_pulse_out_2));
               exp_out = 3 - exp_out;
               lr_cnt++;
            end
            width++;
         end else if (prev_lr) begin
            check("low rate width", 48'(pap_pkg::PULSE_CYC), 48'(width));
            width = 0;
         end
         if (calibration_pulse_out && !prev_cf) begin
            cf_cnt++;
         end
         // Ticks must come exactly one sample period apart.
         if (sample_tick === 1'b1) begin
            if (gap > 0) begin
               check("tick period", 48'(pap_pkg::SAMPLE_DIV), 48'(gap));
            end
            gap = 1;
         end else if (gap > 0) begin
            gap++;
         end
      end
      prev_lr = supply_valid && (low_rate_pulse_out_1 || low_rate_pulse_out_2);
      prev_cf = supply_valid && calibration_pulse_out;
   end

   always @(win_done) begin
      check("pulses present", 48'(notes.pop_front()), 48'(lr_cnt > 0));
   end

   task automatic restart();
      supply_valid <= 0;
      for (int k = 0; k < 10; k++) begin
         @(posedge clk);
         if (k > 3) begin
            check("outputs in reset", 48'h0000_0000_0000, 48'({low_rate_pulse_out_1,
               low_rate_pulse_out_2, calibration_pulse_out}));
            check("tick in reset", 48'h0000_0000_0000, 48'(sample_tick));
         end
      end
      supply_valid <= 1;
   endtask

   task automatic run_window(int ticks, bit expect_pulses);
      int waited;
      notes.push_back(expect_pulses);
      for (int t = 0; t < ticks; t++) begin
         waited = 0;
         do begin
            @(posedge clk);
            waited++;
         end while (sample_tick !== 1'b1 && waited < 140);
         if (waited >= 140) begin
            failures++;
            $display("Error sample tick expected 1 seen 0");
            end_of_test();
         end
      end
      ->win_done;
      @(posedge clk);
   endtask

   initial begin
      logic signed [15:0] a;
      void'($urandom(32'he514fb4d));
      repeat (12) @(posedge clk);
      rst_n <= 1;
      // Large enough that the slowest rate still fires well inside one window.
      a = 16'(20000 + $urandom % 4000);
      amp_i <= '{a, a, a};
      amp_v <= '{a, a, a};
      for (int idx = 0; idx < 4; idx++) begin
         {rate_select_1, rate_select_0} <= 2'(idx);
         restart();
         run_window(100, 1);
         cnt[idx] = lr_cnt;
         if (idx == 0) begin
            check("fast beats slow", 48'h0000_0000_0001, 48'(cf_cnt > lr_cnt));
         end else begin
            check("rate order", 48'h0000_0000_0001, 48'(cnt[idx] >= cnt[idx-1]));
         end
      end
      // Phase B runs reverse power of the same size and phase C carries none.
      amp_i <= '{a, a, 16'h0000};
      amp_v <= '{a, -a, a};
      restart();
      run_window(100, 0);
      sum_method_select <= 0;
      restart();
      run_window(100, 1);
      end_of_test();
   end
endmodule
